// ==== verilog/wdt_pkg.sv ====
// Constants and types of the 16-bit watchdog timer
package wdt_pkg;
    localparam logic [31:0] WDT_RELOAD_ADDR = 32'hFFFF0360;
    localparam logic [31:0] WDT_COUNT_ADDR = 32'hFFFF0364;
    localparam logic [31:0] WDT_CTRL_ADDR = 32'hFFFF0368;
    localparam logic [31:0] WDT_REFRESH_ADDR = 32'hFFFF036C;
    localparam logic [15:0] WDT_RELOAD_RST = 16'h0040;
    localparam logic [15:0] WDT_COUNT_RST = 16'h0040;
    localparam logic [15:0] WDT_CTRL_RST = 16'h0000;
    // Writable control bits: 8..5 and 3..0, bit 4 reserved
    localparam logic [15:0] WDT_CTRL_WMASK = 16'h01EF;
    localparam int WDT_BIT_UP = 8;
    localparam int WDT_BIT_EN = 7;
    localparam int WDT_BIT_PERIODIC = 6;
    localparam int WDT_BIT_WDOG = 5;
    localparam int WDT_BIT_PSC_HI = 3;
    localparam int WDT_BIT_PSC_LO = 2;
    localparam int WDT_BIT_IRQSEL = 1;
    localparam int WDT_BIT_PDSTOP = 0;
    localparam logic [1:0] WDT_PSC_DIV1 = 2'h0;
    localparam logic [1:0] WDT_PSC_DIV16 = 2'h1;
    localparam logic [1:0] WDT_PSC_DIV256 = 2'h2;
    localparam logic [7:0] WDT_PSC_LAST1 = 8'h00;
    localparam logic [7:0] WDT_PSC_LAST16 = 8'h0F;
    localparam logic [7:0] WDT_PSC_LAST256 = 8'hFF;
    localparam int WDT_LP_OSC_HZ = 32768;
    // 65536 counts * 256 / 32768 Hz
    localparam int WDT_MAX_TIMEOUT_S = 512;
    typedef enum logic [1:0]
    {
        WDT_MODE_NORMAL = 2'b01,
        WDT_MODE_WDOG = 2'b10
    } wdt_mode_type;
    typedef struct packed
    {
        wdt_mode_type mode;
        logic [15:0] ctrl;
        logic [15:0] reload;
        logic [15:0] count;
        logic [7:0] presc;
        logic [2:0] lp_sync;
        logic [1:0] dbg_sync;
        logic [1:0] srst_sync;
        logic irq;
        logic rst_req;
        logic [31:0] rdata;
    } wdt_state_type;
endpackage

// ==== verilog/wdt_timer.sv ====
// 16-bit timer with normal and watchdog modes
`timescale 1ns/100ps
module wdt_timer
(
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [31:0] rd_data,
    // System side
    input wire logic lp_osc,
    input wire logic debug_halt,
    input wire logic sys_reset,
    input wire logic periph_powerdown,
    output logic timer_irq,
    output logic cpu_reset_req,
    output logic wdog_active
);
    wdt_pkg::wdt_state_type q;
    wdt_pkg::wdt_state_type d;
    logic lp_edge;
    logic halted;
    logic running;
    logic [1:0] psc_sel;
    logic psc_ok;
    logic [7:0] psc_last;
    logic step;
    logic in_wdog;
    logic wr_reload;
    logic wr_ctrl;
    logic wr_refresh;
    logic wd_zero;

    // Second and third stages only; the first feeds the second alone
    assign lp_edge = q.lp_sync[1] & ~q.lp_sync[2];
    assign halted = q.dbg_sync[1]
        | (periph_powerdown & q.ctrl[wdt_pkg::WDT_BIT_PDSTOP]);
    assign in_wdog = (q.mode == wdt_pkg::WDT_MODE_WDOG);
    // The watchdog runs regardless of the enable bit once armed
    assign running = in_wdog | q.ctrl[wdt_pkg::WDT_BIT_EN];
    assign psc_sel = q.ctrl[wdt_pkg::WDT_BIT_PSC_HI:wdt_pkg::WDT_BIT_PSC_LO];
    // Reserved prescale code stalls the counter rather than guess
    assign psc_ok = (psc_sel != 2'h3);
    assign wd_zero = (q.count <= 16'h0001);
    assign wr_reload = wr_strobe & (addr == wdt_pkg::WDT_RELOAD_ADDR);
    assign wr_ctrl = wr_strobe & (addr == wdt_pkg::WDT_CTRL_ADDR);
    assign wr_refresh = wr_strobe & (addr == wdt_pkg::WDT_REFRESH_ADDR);

    always_comb
    begin
        unique case (psc_sel)
            wdt_pkg::WDT_PSC_DIV16: psc_last = wdt_pkg::WDT_PSC_LAST16;
            wdt_pkg::WDT_PSC_DIV256: psc_last = wdt_pkg::WDT_PSC_LAST256;
            default: psc_last = wdt_pkg::WDT_PSC_LAST1;
        endcase
    end

    assign step = running & ~halted & lp_edge & psc_ok
        & (q.presc == psc_last);

    always_comb
    begin
        d = q;
        d.lp_sync = {q.lp_sync[1:0], lp_osc};
        d.dbg_sync = {q.dbg_sync[0], debug_halt};
        d.srst_sync = {q.srst_sync[0], sys_reset};
        d.rst_req = 1'b0;
        d.rdata = 32'h00000000;
        // Clear first so that a same-cycle event still sets the flag
        if (wr_refresh)
        begin
            d.irq = 1'b0;
        end
        if (running && !halted && lp_edge && psc_ok)
        begin
            d.presc = step ? 8'h00 : q.presc + 8'h01;
        end
        if (step)
        begin
            unique case (q.mode)
                wdt_pkg::WDT_MODE_NORMAL:
                begin
                    if (q.ctrl[wdt_pkg::WDT_BIT_UP])
                    begin
                        if (q.count == 16'hFFFF)
                        begin
                            d.irq = 1'b1;
                            d.count = q.ctrl[wdt_pkg::WDT_BIT_PERIODIC]
                                ? q.reload : 16'h0000;
                        end
                        else
                        begin
                            d.count = q.count + 16'h0001;
                        end
                    end
                    else
                    begin
                        if (q.count == 16'h0000)
                        begin
                            d.irq = 1'b1;
                            d.count = q.ctrl[wdt_pkg::WDT_BIT_PERIODIC]
                                ? q.reload : 16'hFFFF;
                        end
                        else
                        begin
                            d.count = q.count - 16'h0001;
                        end
                    end
                end
                wdt_pkg::WDT_MODE_WDOG:
                begin
                    if (wd_zero)
                    begin
                        // Restart so an unserviced watchdog keeps firing
                        d.count = q.reload;
                        if (q.ctrl[wdt_pkg::WDT_BIT_IRQSEL])
                        begin
                            d.irq = 1'b1;
                        end
                        else
                        begin
                            d.rst_req = 1'b1;
                        end
                    end
                    else
                    begin
                        d.count = q.count - 16'h0001;
                    end
                end
            endcase
        end
        // Only a power-on reset can release an armed watchdog
        if (q.srst_sync[1] && !in_wdog)
        begin
            d.ctrl = wdt_pkg::WDT_CTRL_RST;
            d.reload = wdt_pkg::WDT_RELOAD_RST;
            d.count = wdt_pkg::WDT_COUNT_RST;
            d.presc = 8'h00;
            d.irq = 1'b0;
        end
        if (wr_refresh && in_wdog)
        begin
            d.count = q.reload;
            d.presc = 8'h00;
        end
        if (wr_reload && !in_wdog)
        begin
            d.reload = wr_data[15:0];
        end
        if (wr_ctrl && !in_wdog)
        begin
            d.ctrl = wr_data[15:0] & wdt_pkg::WDT_CTRL_WMASK;
            d.presc = 8'h00;
            if (wr_data[wdt_pkg::WDT_BIT_WDOG])
            begin
                d.mode = wdt_pkg::WDT_MODE_WDOG;
                d.count = q.reload;
            end
        end
        if (rd_strobe)
        begin
            unique case (addr)
                wdt_pkg::WDT_RELOAD_ADDR: d.rdata = {16'h0000, q.reload};
                wdt_pkg::WDT_COUNT_ADDR: d.rdata = {16'h0000, q.count};
                wdt_pkg::WDT_CTRL_ADDR: d.rdata = {16'h0000, q.ctrl};
                default: d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            q.mode <= wdt_pkg::WDT_MODE_NORMAL;
            q.ctrl <= wdt_pkg::WDT_CTRL_RST;
            q.reload <= wdt_pkg::WDT_RELOAD_RST;
            q.count <= wdt_pkg::WDT_COUNT_RST;
            q.presc <= 8'h00;
            q.lp_sync <= 3'h0;
            q.dbg_sync <= 2'h0;
            q.srst_sync <= 2'h0;
            q.irq <= 1'b0;
            q.rst_req <= 1'b0;
            q.rdata <= 32'h00000000;
        end
        else
        begin
            q <= d;
        end
    end

    assign rd_data = q.rdata;
    assign timer_irq = q.irq;
    assign cpu_reset_req = q.rst_req;
    assign wdog_active = q.mode[1];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_wd_fire;
        in_wdog && step && wd_zero;
    endsequence

    sequence s_reset_pulse;
        cpu_reset_req ##1 !cpu_reset_req;
    endsequence

    fire_reset_a: assert property (
        s_wd_fire and !q.ctrl[wdt_pkg::WDT_BIT_IRQSEL] |=> s_reset_pulse)
        else $error("watchdog zero did not pulse reset");

    fire_irq_a: assert property (
        s_wd_fire and q.ctrl[wdt_pkg::WDT_BIT_IRQSEL]
        |=> timer_irq && !cpu_reset_req)
        else $error("watchdog zero did not raise interrupt");

    irq_hold_a: assert property (
        timer_irq && !wr_refresh && !q.srst_sync[1] |=> timer_irq)
        else $error("interrupt dropped without refresh");

    refresh_wd_a: assert property (
        wr_refresh && in_wdog |=> q.count == $past(q.reload))
        else $error("refresh did not reload watchdog");

    clear_irq_a: assert property (
        wr_refresh && !step |=> !timer_irq)
        else $error("refresh did not clear interrupt");

    lock_reload_a: assert property (
        in_wdog |=> q.reload == $past(q.reload) && in_wdog)
        else $error("locked reload value changed");

    lock_ctrl_a: assert property (
        in_wdog |=> q.ctrl == $past(q.ctrl))
        else $error("locked control changed");

    halt_stop_a: assert property (
        q.dbg_sync[1] && !wr_strobe && !q.srst_sync[1]
        |=> q.count == $past(q.count))
        else $error("counter moved while halted");

    count_up_a: assert property (
        step && !in_wdog && q.ctrl[wdt_pkg::WDT_BIT_UP]
        && q.count != 16'hFFFF && !wr_strobe && !q.srst_sync[1]
        |=> q.count == $past(q.count) + 16'h0001)
        else $error("up count did not increment");

    read_count_a: assert property (
        rd_strobe && addr == wdt_pkg::WDT_COUNT_ADDR
        |=> rd_data == {16'h0000, $past(q.count)} ##1 rd_data == 0
            || $past(rd_strobe))
        else $error("count read returned wrong data");

    wd_enter_a: assert property (
        wr_ctrl && !in_wdog && wr_data[wdt_pkg::WDT_BIT_WDOG]
        |=> in_wdog && q.count == $past(q.reload))
        else $error("watchdog mode not entered");

    pd_stop_a: assert property (
        periph_powerdown && q.ctrl[wdt_pkg::WDT_BIT_PDSTOP]
        && !wr_strobe && !q.srst_sync[1] |=> q.count == $past(q.count))
        else $error("counter moved in power-down");

    disabled_hold_a: assert property (
        !in_wdog && !q.ctrl[wdt_pkg::WDT_BIT_EN] && !wr_strobe
        && !q.srst_sync[1] |=> q.count == $past(q.count))
        else $error("disabled timer moved");

    psc_reserved_a: assert property (
        psc_sel == 2'h3 && !wr_strobe && !q.srst_sync[1]
        |=> q.count == $past(q.count))
        else $error("reserved prescale let counter move");

    periodic_reload_a: assert property (
        step && !in_wdog && !q.ctrl[wdt_pkg::WDT_BIT_UP]
        && q.count == 16'h0000 && q.ctrl[wdt_pkg::WDT_BIT_PERIODIC]
        && !wr_strobe && !q.srst_sync[1]
        |=> q.count == $past(q.reload) && timer_irq)
        else $error("periodic timer did not reload");

    free_run_a: assert property (
        step && !in_wdog && !q.ctrl[wdt_pkg::WDT_BIT_UP]
        && q.count == 16'h0000 && !q.ctrl[wdt_pkg::WDT_BIT_PERIODIC]
        && !wr_strobe && !q.srst_sync[1]
        |=> q.count == 16'hFFFF && timer_irq)
        else $error("free-running timer did not wrap");

    wd_down_a: assert property (
        step && in_wdog && !wd_zero && !wr_refresh
        |=> q.count == $past(q.count) - 16'h0001)
        else $error("watchdog did not count down");

    wd_irq_only_a: assert property (
        in_wdog && q.ctrl[wdt_pkg::WDT_BIT_IRQSEL] |-> !cpu_reset_req)
        else $error("interrupt option raised reset");

    read_reload_a: assert property (
        rd_strobe && addr == wdt_pkg::WDT_RELOAD_ADDR
        |=> rd_data == {16'h0000, $past(q.reload)})
        else $error("reload read returned wrong data");
endmodule

// ==== tb/tb_wdt_timer_16bit.sv ====
// Self-checking bench of the 16-bit watchdog timer
`timescale 1ns/100ps
module tb_wdt_timer_16bit;
    logic mclk, rst, wr_strobe, rd_strobe, lp_osc, debug_halt;
    logic sys_reset, periph_powerdown, timer_irq, cpu_reset_req;
    logic wdog_active;
    logic [31:0] addr, wr_data, rd_data;
    int bad_count, comparisons, pulses, m_rld, m_cnt;
    int seed = 32'h4DB7;
    // Shortest watchdog period software may use: 30 ms of ticks at /1
    localparam int WD_MIN_TICKS = 984;

    wdt_timer u_wdt_timer
    (
        .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .lp_osc(lp_osc), .debug_halt(debug_halt), .sys_reset(sys_reset),
        .periph_powerdown(periph_powerdown), .timer_irq(timer_irq),
        .cpu_reset_req(cpu_reset_req), .wdog_active(wdog_active)
    );

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Pulses last one cycle, so sample on the falling edge
    always @(negedge mclk)
        if (cpu_reset_req === 1'b1)
            pulses++;

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge mclk);
        wr_strobe <= 1'b0;
        // Idle cycle so callers see the register already updated
        @(posedge mclk);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge mclk);
        rd_strobe <= 1'b0;
        @(posedge mclk);
        chk_reg(rd_data, exp);
    endtask

    // One oscillator period; the tick lands 3 mclk after the rise
    task automatic tick(input int n);
        repeat (n)
        begin
            lp_osc <= 1'b1;
            repeat (6) @(posedge mclk);
            lp_osc <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask

    initial
    begin
        {rst, wr_strobe, rd_strobe, lp_osc, debug_halt} = 5'h10;
        {sys_reset, periph_powerdown, addr, wr_data} = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(wdt_pkg::WDT_RELOAD_ADDR, 32'h40);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h40);
        rd(wdt_pkg::WDT_CTRL_ADDR, 32'h0);
        rd(wdt_pkg::WDT_REFRESH_ADDR, 32'h0);
        rd(32'hFFFF0370, 32'h0);
        chk_pin(wdog_active, 1'b0);
        m_rld = $random(seed);
        wr(wdt_pkg::WDT_RELOAD_ADDR, m_rld);
        rd(wdt_pkg::WDT_RELOAD_ADDR, m_rld & 32'hFFFF);
        wr(wdt_pkg::WDT_COUNT_ADDR, 32'h1234);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h40);
        $display("test registers done");
        m_rld = 3;
        wr(wdt_pkg::WDT_RELOAD_ADDR, m_rld);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'hC0);
        tick(32'h40);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h0);
        chk_pin(timer_irq, 1'b0);
        tick(1);
        chk_pin(timer_irq, 1'b1);
        rd(wdt_pkg::WDT_COUNT_ADDR, m_rld);
        tick(1);
        wr(wdt_pkg::WDT_REFRESH_ADDR, 32'h5A);
        chk_pin(timer_irq, 1'b0);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h2);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'hC4);
        tick(15);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h2);
        tick(1);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h1);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h1C0);
        tick(1);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h2);
        debug_halt <= 1'b1;
        tick(2);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h2);
        debug_halt <= 1'b0;
        periph_powerdown <= 1'b1;
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h1C1);
        tick(2);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h2);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h1C0);
        tick(1);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h3);
        periph_powerdown <= 1'b0;
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h140);
        tick(1);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h3);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h1C8);
        tick(255);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h3);
        tick(1);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h4);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h1CC);
        tick(2);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h4);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h80);
        tick(4);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h0);
        tick(1);
        chk_pin(timer_irq, 1'b1);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'hFFFF);
        wr(wdt_pkg::WDT_REFRESH_ADDR, 32'h0);
        chk_pin(timer_irq, 1'b0);
        $display("test normal mode done");
        m_rld = WD_MIN_TICKS;
        wr(wdt_pkg::WDT_RELOAD_ADDR, m_rld);
        m_cnt = m_rld;
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'hA2);
        chk_pin(wdog_active, 1'b1);
        wr(wdt_pkg::WDT_RELOAD_ADDR, 32'h9);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h0);
        rd(wdt_pkg::WDT_RELOAD_ADDR, m_rld);
        rd(wdt_pkg::WDT_CTRL_ADDR, 32'hA2);
        pulses = 0;
        repeat (2)
        begin
            tick(1);
            m_cnt--;
            rd(wdt_pkg::WDT_COUNT_ADDR, m_cnt);
        end
        tick(m_cnt - 1);
        rd(wdt_pkg::WDT_COUNT_ADDR, 32'h1);
        tick(1);
        chk_pin(timer_irq, 1'b1);
        chk_reg(pulses, 0);
        rd(wdt_pkg::WDT_COUNT_ADDR, m_rld);
        tick(1);
        wr(wdt_pkg::WDT_REFRESH_ADDR, 32'h0);
        chk_pin(timer_irq, 1'b0);
        rd(wdt_pkg::WDT_COUNT_ADDR, m_rld);
        sys_reset <= 1'b1;
        repeat (6) @(posedge mclk);
        sys_reset <= 1'b0;
        tick(1);
        chk_pin(wdog_active, 1'b1);
        rd(wdt_pkg::WDT_COUNT_ADDR, m_rld - 1);
        $display("test watchdog interrupt done");
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk_pin(wdog_active, 1'b0);
        m_rld = WD_MIN_TICKS + ($random(seed) & 32'hFF);
        wr(wdt_pkg::WDT_RELOAD_ADDR, m_rld);
        wr(wdt_pkg::WDT_CTRL_ADDR, 32'h20);
        pulses = 0;
        tick(1);
        rd(wdt_pkg::WDT_COUNT_ADDR, m_rld - 1);
        tick(m_rld - 2);
        chk_reg(pulses, 0);
        tick(1);
        chk_reg(pulses, 1);
        chk_pin(timer_irq, 1'b0);
        rd(wdt_pkg::WDT_COUNT_ADDR, m_rld);
        $display("test watchdog reset done");
        test_done();
    end

    // A hang counts as a mismatch
    initial
    begin
        #2000000;
        bad_count++;
        test_done();
    end
endmodule
